// File: hw/pocr_pkg.sv
// Shared constants for the PLL output configuration register bank
package pocr_pkg;
  // Register offsets on the control port
  localparam logic [7:0] POCR_AUX_SRC_OFS   = 8'h03;
  localparam logic [7:0] POCR_RATIO0_OFS    = 8'h06;
  localparam logic [7:0] POCR_RATIO3_OFS    = 8'h09;
  localparam logic [7:0] POCR_FUNC_CFG1_OFS = 8'h16;
  localparam logic [7:0] POCR_FUNC_CFG2_OFS = 8'h17;
  // Field positions
  localparam int POCR_AUX_SRC_LSB   = 1;
  localparam int POCR_LOCK_STYLE_B  = 6;
  localparam int POCR_REF_DIV_LSB   = 3;
  localparam int POCR_OWU_BIT       = 4;
  localparam int POCR_RATIO_FRAC_W  = 20;
  localparam int POCR_RATIO_INT_W   = 12;
  // Field encodings
  localparam logic [1:0] POCR_SRC_REF    = 2'h0;
  localparam logic [1:0] POCR_SRC_CLKOUT = 2'h2;
  localparam logic [1:0] POCR_SRC_LOCK   = 2'h3;
  localparam logic [1:0] POCR_DIV_BY4    = 2'h0;
  localparam logic [1:0] POCR_DIV_BY2    = 2'h1;
  localparam logic [1:0] POCR_DIV_BY1    = 2'h2;
  // Reset values
  localparam logic [1:0]  POCR_AUX_SRC_RST   = 2'h0;
  localparam logic        POCR_LOCK_STYLE_RST = 1'b0;
  localparam logic [1:0]  POCR_REF_DIV_RST   = 2'h0;
  localparam logic        POCR_OWU_RST       = 1'b0;
  localparam logic [31:0] POCR_RATIO_RST     = 32'h0000_0000;
endpackage

// File: hw/pocr_cfg_if.sv
// Configuration and status carried from the register bank to the pin driver
`timescale 1ns/10ps
interface pocr_cfg_if;
  logic [1:0] aux_source_select;
  logic       lock_pin_style;
  logic       output_while_unlocked;
  logic       unlocked;
  logic       pll_clk;
  logic       ref_tick;
  modport regs (output aux_source_select, output lock_pin_style,
                output output_while_unlocked, output unlocked,
                output pll_clk, output ref_tick);
  modport drv  (input aux_source_select, input lock_pin_style,
                input output_while_unlocked, input unlocked,
                input pll_clk, input ref_tick);
endinterface

// File: hw/pocr_pin_drv.sv
// Auxiliary pin and clock output driver
`timescale 1ns/10ps
module pocr_pin_drv
  import pocr_pkg::*;
(
  input  wire logic  core_clk_in,
  input  wire logic  rst_in,
  pocr_cfg_if.drv    cfg,
  output logic       clk_out_out,
  output logic       aux_pin_out,
  output logic       aux_pin_oe_out
);
  // Pin selection, style only matters in lock indicator mode
  wire lock_mode   = (cfg.aux_source_select == POCR_SRC_LOCK);
  wire clk_gate    = cfg.unlocked & ~cfg.output_while_unlocked;
  wire next_clk    = cfg.pll_clk & ~clk_gate;
  wire lock_level  = cfg.lock_pin_style ? 1'b0 : cfg.unlocked;
  wire lock_oe     = cfg.lock_pin_style ? cfg.unlocked : 1'b1;
  wire src_level   = (cfg.aux_source_select == POCR_SRC_REF)    ? cfg.ref_tick :
                     (cfg.aux_source_select == POCR_SRC_CLKOUT) ? next_clk : 1'b0;
  wire next_aux    = lock_mode ? lock_level : src_level;
  wire next_aux_oe = lock_mode ? lock_oe : 1'b1;

  // Outputs come from flip-flops so the pins never glitch on a select change
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_out_out    <= 1'b0;
      aux_pin_out    <= 1'b0;
      aux_pin_oe_out <= 1'b0;
    end else begin
      clk_out_out    <= next_clk;
      aux_pin_out    <= next_aux;
      aux_pin_oe_out <= next_aux_oe;
    end
  end

  property p_push_pull;
    @(posedge core_clk_in) disable iff (rst_in)
    (lock_mode && !cfg.lock_pin_style) |=> (aux_pin_oe_out && aux_pin_out == $past(cfg.unlocked));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull lock pin wrong");

  property p_open_drain;
    @(posedge core_clk_in) disable iff (rst_in)
    (lock_mode && cfg.lock_pin_style) |=> (!aux_pin_out && aux_pin_oe_out == $past(cfg.unlocked));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain lock pin wrong");

  property p_style_ignored;
    @(posedge core_clk_in) disable iff (rst_in)
    (cfg.aux_source_select == POCR_SRC_CLKOUT) |=> (aux_pin_oe_out && aux_pin_out == clk_out_out);
  endproperty
  a_style_ignored: assert property (p_style_ignored) else $error("aux clock not passed");

  property p_lock_only;
    @(posedge core_clk_in) disable iff (rst_in)
    (!lock_mode) |=> aux_pin_oe_out;
  endproperty
  a_lock_only: assert property (p_lock_only) else $error("style applied outside lock mode");

  property p_hold_low;
    @(posedge core_clk_in) disable iff (rst_in)
    (cfg.unlocked && !cfg.output_while_unlocked) |=> !clk_out_out;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock not held low on unlock");

  property p_always_on;
    @(posedge core_clk_in) disable iff (rst_in)
    cfg.output_while_unlocked |=> (clk_out_out == $past(cfg.pll_clk));
  endproperty
  a_always_on: assert property (p_always_on) else $error("clock gated while enabled");
endmodule

// File: hw/pocr_regs.sv
// PLL output configuration register bank, top level
// Overview of operation
// - Lock pin style applies only when source 11
// - Clock source on aux pin ignores style
// - Style 0: push-pull, high when unlocked
// - Style 1: open drain, low when unlocked
// - Reference divider codes 00/01/10 divide 4/2/1
// - Output bit 0 holds clocks low unlocked
// - Output bit 1 keeps clocks always running
// - User ratio is unsigned 12.20 fixed point
// - Register 17h holds output control bit 4
// - Ratio is four bytes, MSB lowest address
`timescale 1ns/10ps
module pocr_regs
  import pocr_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        pll_unlock_in,
  input  wire logic        pll_clk_in,
  output logic      [31:0] user_ratio_out,
  output logic             ref_div_tick_out,
  output logic             clk_out_out,
  output logic             aux_pin_out,
  output logic             aux_pin_oe_out
);
  pocr_cfg_if cfg_bus ();

  logic [1:0]  aux_source_select;
  logic        lock_pin_style;
  logic [1:0]  ref_input_divider;
  logic        output_while_unlocked;
  logic [7:0]  ratio_byte [4];
  logic        unlock_meta;
  logic        unlock_sync;
  logic [1:0]  div_cnt;

  // Terminal count of the reference divider; reserved code runs undivided
  function automatic logic [1:0] div_last(input logic [1:0] code);
    unique case (code)
      POCR_DIV_BY4: div_last = 2'h3;
      POCR_DIV_BY2: div_last = 2'h1;
      POCR_DIV_BY1: div_last = 2'h0;
      default:      div_last = 2'h0;
    endcase
  endfunction

  // Address decode
  wire wr_src   = reg_wr_in && (reg_addr_in == POCR_AUX_SRC_OFS);
  wire wr_cfg1  = reg_wr_in && (reg_addr_in == POCR_FUNC_CFG1_OFS);
  wire wr_cfg2  = reg_wr_in && (reg_addr_in == POCR_FUNC_CFG2_OFS);
  wire in_ratio = (reg_addr_in >= POCR_RATIO0_OFS) && (reg_addr_in <= POCR_RATIO3_OFS);
  wire [1:0] ratio_idx = reg_addr_in[1:0] - POCR_RATIO0_OFS[1:0];

  // Read mux; reserved positions and unmapped offsets read zero
  wire [7:0] rd_src  = {5'h00, aux_source_select, 1'b0};
  wire [7:0] rd_cfg1 = {1'b0, lock_pin_style, 1'b0, ref_input_divider, 3'h0};
  wire [7:0] rd_cfg2 = {3'h0, output_while_unlocked, 4'h0};
  wire [7:0] rd_mux  = (reg_addr_in == POCR_AUX_SRC_OFS)   ? rd_src  :
                       (reg_addr_in == POCR_FUNC_CFG1_OFS) ? rd_cfg1 :
                       (reg_addr_in == POCR_FUNC_CFG2_OFS) ? rd_cfg2 :
                       in_ratio ? ratio_byte[ratio_idx] : 8'h00;

  // Ratio bytes joined MSB first: 12 integer bits over 20 fraction bits
  assign user_ratio_out = {ratio_byte[0], ratio_byte[1], ratio_byte[2], ratio_byte[3]};

  // Configuration registers; only the defined fields are stored
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aux_source_select     <= POCR_AUX_SRC_RST;
      lock_pin_style        <= POCR_LOCK_STYLE_RST;
      ref_input_divider     <= POCR_REF_DIV_RST;
      output_while_unlocked <= POCR_OWU_RST;
    end else begin
      if (wr_src)
        aux_source_select <= reg_wdata_in[POCR_AUX_SRC_LSB +: 2];
      if (wr_cfg1) begin
        lock_pin_style    <= reg_wdata_in[POCR_LOCK_STYLE_B];
        ref_input_divider <= reg_wdata_in[POCR_REF_DIV_LSB +: 2];
      end
      if (wr_cfg2)
        output_while_unlocked <= reg_wdata_in[POCR_OWU_BIT];
    end
  end

  // Ratio byte storage, one byte per offset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        ratio_byte[i] <= POCR_RATIO_RST[8*(3-i) +: 8];
      end
    end else if (reg_wr_in && in_ratio) begin
      ratio_byte[ratio_idx] <= reg_wdata_in;
    end
  end

  // Read data is registered, valid the cycle after the read strobe
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
  end

  // Unlock flag comes from the analog loop, so it is synchronised first
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      unlock_meta <= 1'b1;
      unlock_sync <= 1'b1;
    end else begin
      unlock_meta <= pll_unlock_in;
      unlock_sync <= unlock_meta;
    end
  end

  // Reference divider producing a one-cycle enable
  wire div_wrap = (div_cnt >= div_last(ref_input_divider));
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt          <= 2'h0;
      ref_div_tick_out <= 1'b0;
    end else begin
      div_cnt          <= div_wrap ? 2'h0 : div_cnt + 2'h1;
      ref_div_tick_out <= div_wrap;
    end
  end

  assign cfg_bus.aux_source_select     = aux_source_select;
  assign cfg_bus.lock_pin_style        = lock_pin_style;
  assign cfg_bus.output_while_unlocked = output_while_unlocked;
  assign cfg_bus.unlocked              = unlock_sync;
  assign cfg_bus.pll_clk               = pll_clk_in;
  assign cfg_bus.ref_tick              = ref_div_tick_out;

  pocr_pin_drv u_pin_drv (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .cfg            (cfg_bus.drv),
    .clk_out_out    (clk_out_out),
    .aux_pin_out    (aux_pin_out),
    .aux_pin_oe_out (aux_pin_oe_out)
  );

  // A divider write inside the gap shortens it legally, so the window must be write free
  property p_div_by4;
    @(posedge core_clk_in) disable iff (rst_in)
    (ref_div_tick_out && ref_input_divider == POCR_DIV_BY4 && !wr_cfg1) ##1 (!wr_cfg1) [*2]
      |-> (!$past(ref_div_tick_out) && !ref_div_tick_out) ##1 !ref_div_tick_out
          ##1 ref_div_tick_out;
  endproperty
  a_div_by4: assert property (p_div_by4) else $error("divide by 4 spacing wrong");

  property p_div_by1;
    @(posedge core_clk_in) disable iff (rst_in)
    (ref_input_divider == POCR_DIV_BY1 && $past(ref_input_divider) == POCR_DIV_BY1)
      |=> ref_div_tick_out;
  endproperty
  a_div_by1: assert property (p_div_by1) else $error("divide by 1 missing tick");

  property p_div_by2;
    @(posedge core_clk_in) disable iff (rst_in)
    (ref_div_tick_out && ref_input_divider == POCR_DIV_BY2 && !wr_cfg1)
      |=> !ref_div_tick_out ##1 ref_div_tick_out;
  endproperty
  a_div_by2: assert property (p_div_by2) else $error("divide by 2 spacing wrong");

  property p_cfg2_read;
    @(posedge core_clk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == POCR_FUNC_CFG2_OFS)
      |=> (reg_rdata_out == {3'h0, $past(output_while_unlocked), 4'h0});
  endproperty
  a_cfg2_read: assert property (p_cfg2_read) else $error("offset 17h readback wrong");

  property p_reserved_zero;
    @(posedge core_clk_in) disable iff (rst_in)
    (wr_cfg2 ##[1:2] (reg_rd_in && reg_addr_in == POCR_FUNC_CFG2_OFS && !reg_wr_in))
      |=> (reg_rdata_out[7:5] == 3'h0 && reg_rdata_out[3:0] == 4'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_ratio_msb;
    @(posedge core_clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == POCR_RATIO0_OFS)
      |=> (user_ratio_out[31:24] == $past(reg_wdata_in));
  endproperty
  a_ratio_msb: assert property (p_ratio_msb) else $error("ratio MSB not at lowest offset");

  property p_ratio_lsb;
    @(posedge core_clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == POCR_RATIO3_OFS)
      |=> (user_ratio_out[POCR_RATIO_FRAC_W-13:0] == $past(reg_wdata_in));
  endproperty
  a_ratio_lsb: assert property (p_ratio_lsb) else $error("ratio LSB byte wrong");

  property p_ratio_byte1;
    @(posedge core_clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == POCR_RATIO0_OFS + 8'h01)
      |=> (user_ratio_out[23:16] == $past(reg_wdata_in));
  endproperty
  a_ratio_byte1: assert property (p_ratio_byte1) else $error("ratio second byte wrong");

  property p_owu_set;
    @(posedge core_clk_in) disable iff (rst_in)
    (wr_cfg2 && reg_wdata_in[POCR_OWU_BIT]) |=> output_while_unlocked;
  endproperty
  a_owu_set: assert property (p_owu_set) else $error("output control bit not set");

  property p_owu_clear;
    @(posedge core_clk_in) disable iff (rst_in)
    (wr_cfg2 && !reg_wdata_in[POCR_OWU_BIT]) |=> !output_while_unlocked;
  endproperty
  a_owu_clear: assert property (p_owu_clear) else $error("output control bit not cleared");

  // Offsets outside the map must never leak a stale byte onto the read port
  property p_unmapped_zero;
    @(posedge core_clk_in) disable iff (rst_in)
    (reg_rd_in && !in_ratio && reg_addr_in != POCR_AUX_SRC_OFS &&
     reg_addr_in != POCR_FUNC_CFG1_OFS && reg_addr_in != POCR_FUNC_CFG2_OFS)
      |=> (reg_rdata_out == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped offset not zero");
endmodule

// File: testbench/pocr_pll_model.sv
// Behavioural PLL seen by the register bank: clock level and lock flag
`timescale 1ns/10ps
module pocr_pll_model (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic unlock_req_in,
  output logic      pll_clk_out,
  output logic      pll_unlock_out
);
  // Clock keeps running while unlocked, as a real loop would
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pll_clk_out <= 1'b0;
    end else begin
      pll_clk_out <= ~pll_clk_out;
    end
  end
  // Lock flag is a plain level; the block synchronises it
  assign pll_unlock_out = unlock_req_in;
endmodule

// File: testbench/test_pocr_regs.sv
// Self-checking bench for the PLL output configuration register bank
`timescale 1ns/10ps
module test_pocr_regs;
  import pocr_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic [7:0]  addr        = 8'h00;
  logic [7:0]  wdata       = 8'h00;
  logic        unlock      = 1'b1;
  logic [7:0]  rdata;
  logic        pll_clk;
  logic        pll_unl;
  logic [31:0] ratio;
  logic        tick;
  logic        clk_o;
  logic        aux;
  logic        aux_oe;
  logic [7:0]  ofs [7] = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h16, 8'h17};
  logic [7:0]  rb [4]  = '{8'h00, 8'h13, 8'ha9, 8'h2a};
  int          miscompares = 0;
  int          compares    = 0;
  int          c;

  pocr_pll_model i_pocr_pll_model (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .unlock_req_in(unlock), .pll_clk_out(pll_clk), .pll_unlock_out(pll_unl));
  pocr_regs i_pocr_regs (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .pll_unlock_in(pll_unl), .pll_clk_in(pll_clk), .user_ratio_out(ratio),
    .ref_div_tick_out(tick), .clk_out_out(clk_o), .aux_pin_out(aux),
    .aux_pin_oe_out(aux_oe));

  // 50 MHz system clock
  always #10 core_clk_in = ~core_clk_in;

  // Single compare point, case equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe, taken at the next edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk_in);
    wr    <= 1'b0;
  endtask
  // Read data is sampled a full cycle late since it holds until the next read
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk_in);
    rd   <= 1'b0;
    @(posedge core_clk_in);
    #1 chk(rdata, exp);
  endtask
  // Count highs of the tick (sel 0) or the clock output (sel 1)
  task automatic cnt(input bit sel, input int n);
    c = 0;
    repeat (n) begin
      @(posedge core_clk_in);
      #1;
      if ((sel ? clk_o : tick) === 1'b1) c++;
    end
  endtask
  // Unlock changes pass a two-stage synchroniser, so allow settling time
  task automatic pll(input logic u);
    @(posedge core_clk_in);
    unlock <= u;
    repeat (6) @(posedge core_clk_in);
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog; the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk_in);
    miscompares++;
    results();
  end

  initial begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    foreach (ofs[i]) rd_reg(ofs[i], 8'h00);
    wr_reg(8'h20, 8'hff);
    rd_reg(8'h20, 8'h00);
    wr_reg(POCR_FUNC_CFG1_OFS, 8'hff);
    rd_reg(POCR_FUNC_CFG1_OFS, 8'h58);
    wr_reg(POCR_FUNC_CFG2_OFS, 8'hff);
    rd_reg(POCR_FUNC_CFG2_OFS, 8'h10);
    $display("test registers done");
    // Host writes a 12.20 ratio, high byte at the lowest offset
    foreach (rb[i]) wr_reg(8'(POCR_RATIO0_OFS + i), rb[i]);
    #1 chk(ratio, 32'h0013a92a);
    rd_reg(POCR_RATIO3_OFS, 8'h2a);
    wr_reg(POCR_RATIO0_OFS, 8'h10);
    #1 chk(ratio, 32'h1013a92a);
    $display("test ratio done");
    // Divide by 4, 2, 1 gives 6, 12, 24 ticks in 24 cycles
    for (int k = 0; k < 3; k++) begin
      wr_reg(POCR_FUNC_CFG1_OFS, 8'(k << 3));
      repeat (4) @(posedge core_clk_in);
      cnt(1'b0, 24);
      chk(c, 6 << k);
    end
    $display("test divider done");
    // Lock indicator in both styles and both lock states
    wr_reg(POCR_AUX_SRC_OFS, 8'h06);
    for (int s = 0; s < 2; s++) begin
      wr_reg(POCR_FUNC_CFG1_OFS, s ? 8'h40 : 8'h00);
      for (int u = 0; u < 2; u++) begin
        pll(u[0]);
        chk(aux_oe, !(s && !u));
        if (!(s && !u)) chk(aux, s ? 1'b0 : u[0]);
      end
    end
    // Locked, style 1: clock sources must still drive the pin
    pll(1'b0);
    wr_reg(POCR_AUX_SRC_OFS, 8'h04);
    repeat (4) @(posedge core_clk_in);
    chk(aux_oe, 1'b1);
    // Reserved source drives the pin low, style still ignored
    wr_reg(POCR_AUX_SRC_OFS, 8'h02);
    repeat (2) @(posedge core_clk_in);
    #1 chk(aux_oe, 1'b1);
    chk(aux, 1'b0);
    wr_reg(POCR_AUX_SRC_OFS, 8'h00);
    repeat (4) @(posedge core_clk_in);
    chk(aux_oe, 1'b1);
    $display("test aux pin done");
    // Clock output gating while unlocked
    wr_reg(POCR_FUNC_CFG2_OFS, 8'h00);
    cnt(1'b1, 8);
    chk(c, 4);
    pll(1'b1);
    cnt(1'b1, 8);
    chk(c, 0);
    wr_reg(POCR_FUNC_CFG2_OFS, 8'h10);
    repeat (2) @(posedge core_clk_in);
    cnt(1'b1, 8);
    chk(c, 4);
    $display("test clock gating done");
    results();
  end
endmodule
